// >>> nbpm_params.svh
// address map, field positions and reset values of the nibble port block
`ifndef NBPM_PARAMS_SVH
`define NBPM_PARAMS_SVH

`define NBPM_NIB_W 4
`define NBPM_DM_AW 7
`define NBPM_RF_AW 6

// data memory locations (bank, address)
`define NBPM_BANK0 1'h0
`define NBPM_BANK1 1'h1
`define NBPM_AC_DATA_ADDR 7'h72
`define NBPM_SP_DATA_ADDR 7'h73
`define NBPM_B1_DATA_ADDR 7'h70

// register file locations
`define NBPM_ALT_SEL_ADDR 6'h0b
`define NBPM_ANA_SEL_ADDR 6'h1b
`define NBPM_AC_DIR_ADDR 6'h1c
`define NBPM_CHAN_SEL_ADDR 6'h22
`define NBPM_SP_DIR_ADDR 6'h2b
`define NBPM_GRP_DIR_ADDR 6'h2c

// field positions
`define NBPM_SERIAL_EN_BIT 0
`define NBPM_TIMER_SEL_BIT 3
`define NBPM_B1_GRP_BIT 2
`define NBPM_SCK_BIT 0
`define NBPM_SO_BIT 1
`define NBPM_SI_BIT 2
`define NBPM_TMR_BIT 3

// reset values
`define NBPM_NIB_RST 4'h0
`define NBPM_CHAN_RST 2'h0
`define NBPM_TMR_OUT_RST 1'h1
`define NBPM_ALL_HIGH 4'hf

`endif

// >>> nbpm_pkg.sv
// types of the nibble port block
`include "nbpm_params.svh"

package nbpm_pkg;

  typedef logic [`NBPM_NIB_W-1:0] nbpm_nib_type;

  typedef struct packed {
    nbpm_nib_type ac_lat;
    nbpm_nib_type ac_dir;
    nbpm_nib_type ana_sel;
    logic [1:0] chan;
    nbpm_nib_type sp_lat;
    nbpm_nib_type sp_dir;
    nbpm_nib_type alt_sel;
    nbpm_nib_type b1_lat;
    nbpm_nib_type grp_dir;
    logic tmr_out;
    nbpm_nib_type dm_rdata;
    nbpm_nib_type rf_rdata;
    nbpm_nib_type ac_out;
    nbpm_nib_type ac_oe_n;
    nbpm_nib_type sp_oe_n;
    nbpm_nib_type b1_oe_n;
    nbpm_nib_type route;
    logic [1:0] conv_chan;
  } nbpm_state_type;

endpackage

// >>> nbpm_pin_sync.sv
// three-stage pin synchroniser that accepts a level once stages two and three agree
module nbpm_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only; the agreement check looks at stages two and three
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      o_level <= '0;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
        begin
          o_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// >>> nbpm_top.sv
// three nibble ports with analog, serial and timer pin sharing
`include "nbpm_params.svh"

module nbpm_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // data memory side
  input wire logic i_dm_bank,
  input wire logic [`NBPM_DM_AW-1:0] i_dm_addr,
  input wire logic i_dm_wr,
  input wire logic i_dm_rd,
  input wire nbpm_pkg::nbpm_nib_type i_dm_wdata,
  output nbpm_pkg::nbpm_nib_type o_dm_rdata,
  // register file side
  input wire logic [`NBPM_RF_AW-1:0] i_rf_addr,
  input wire logic i_rf_wr,
  input wire logic i_rf_rd,
  input wire nbpm_pkg::nbpm_nib_type i_rf_wdata,
  output nbpm_pkg::nbpm_nib_type o_rf_rdata,
  // analog capable port pins
  input wire nbpm_pkg::nbpm_nib_type i_ac_pin,
  output nbpm_pkg::nbpm_nib_type o_ac_pin_out,
  output nbpm_pkg::nbpm_nib_type o_ac_pin_oe_n,
  output nbpm_pkg::nbpm_nib_type o_analog_route,
  output logic [1:0] o_conv_chan,
  // shared function port pins (open drain)
  input wire nbpm_pkg::nbpm_nib_type i_sp_pin,
  output nbpm_pkg::nbpm_nib_type o_sp_pin_out,
  output nbpm_pkg::nbpm_nib_type o_sp_pin_oe_n,
  // bank1 open drain port pins
  input wire nbpm_pkg::nbpm_nib_type i_b1_pin,
  output nbpm_pkg::nbpm_nib_type o_b1_pin_out,
  output nbpm_pkg::nbpm_nib_type o_b1_pin_oe_n,
  // serial shifter and timer, same clock
  input wire logic i_sck_internal,
  input wire logic i_sck_drive,
  input wire logic i_so_drive,
  input wire logic i_so_latch_load,
  input wire logic i_so_latch_val,
  input wire logic i_tmr_reset,
  input wire logic i_tmr_match,
  output logic o_serial_pins_enable,
  output logic o_serial_clk_in,
  output logic o_serial_data_in,
  output logic o_timer_toggle_output
);

  import nbpm_pkg::*;

  // ****************************************
  // state and synchronised pin levels
  // ****************************************
  nbpm_state_type state;
  nbpm_state_type next_state;
  nbpm_nib_type ac_level;
  nbpm_nib_type sp_level;
  nbpm_nib_type b1_level;
  logic serial_pins_enable;
  logic timer_pin_select;
  logic bank1_group_dir;
  logic serial_q;
  logic sck_q;
  logic si_q;

  nbpm_pin_sync #(
    .WIDTH(`NBPM_NIB_W)
  ) u_ac_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_ac_pin),
    .o_level(ac_level)
  );

  nbpm_pin_sync #(
    .WIDTH(`NBPM_NIB_W)
  ) u_sp_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_sp_pin),
    .o_level(sp_level)
  );

  nbpm_pin_sync #(
    .WIDTH(`NBPM_NIB_W)
  ) u_b1_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_b1_pin),
    .o_level(b1_level)
  );

  assign serial_pins_enable = state.alt_sel[`NBPM_SERIAL_EN_BIT];
  assign timer_pin_select = state.alt_sel[`NBPM_TIMER_SEL_BIT];
  assign bank1_group_dir = state.grp_dir[`NBPM_B1_GRP_BIT];

  // ****************************************
  // read-back views of the three ports
  // ****************************************
  function automatic nbpm_nib_type nbpm_mix(input nbpm_nib_type use_lat, input nbpm_nib_type lat,
                                            input nbpm_nib_type pin);
    nbpm_mix = (use_lat & lat) | (~use_lat & pin);
  endfunction

  nbpm_nib_type ac_view;
  nbpm_nib_type sp_view;
  nbpm_nib_type b1_view;
  nbpm_nib_type sp_use_lat;

  always_comb
  begin
    ac_view = nbpm_mix(state.ac_dir | state.ana_sel, state.ac_lat, ac_level);
    sp_use_lat = state.sp_dir;
    if (serial_pins_enable)
    begin
      sp_use_lat[`NBPM_SCK_BIT] = i_sck_internal;
      // data-out reads back as undefined; returning the latch keeps it deterministic
      sp_use_lat[`NBPM_SO_BIT] = 1'b1;
      sp_use_lat[`NBPM_SI_BIT] = 1'b0;
    end
    if (timer_pin_select)
    begin
      sp_use_lat[`NBPM_TMR_BIT] = 1'b1;
    end
    sp_view = nbpm_mix(sp_use_lat, state.sp_lat, sp_level);
    b1_view = bank1_group_dir ? state.b1_lat : b1_level;
  end

  // ****************************************
  // next state
  // ****************************************
  logic dm_b0;
  logic dm_b1;

  assign dm_b0 = (i_dm_bank == `NBPM_BANK0);
  assign dm_b1 = (i_dm_bank == `NBPM_BANK1);

  always_comb
  begin
    next_state = state;

    // register file writes
    if (i_rf_wr)
    begin
      case (i_rf_addr)
        `NBPM_ALT_SEL_ADDR:
        begin
          next_state.alt_sel = i_rf_wdata;
        end
        `NBPM_ANA_SEL_ADDR:
        begin
          next_state.ana_sel = i_rf_wdata;
        end
        `NBPM_AC_DIR_ADDR:
        begin
          next_state.ac_dir = i_rf_wdata;
        end
        `NBPM_CHAN_SEL_ADDR:
        begin
          next_state.chan = i_rf_wdata[1:0];
        end
        `NBPM_SP_DIR_ADDR:
        begin
          next_state.sp_dir = i_rf_wdata;
        end
        `NBPM_GRP_DIR_ADDR:
        begin
          next_state.grp_dir = i_rf_wdata;
        end
        default:
        begin
          next_state.grp_dir = state.grp_dir;
        end
      endcase
    end

    // shifter traffic can leave its bit in the data-out latch
    if (i_so_latch_load && serial_pins_enable)
    begin
      next_state.sp_lat[`NBPM_SO_BIT] = i_so_latch_val;
    end

    // cpu write lands last so it overrides the shifter in the same cycle
    if (i_dm_wr && dm_b0 && i_dm_addr == `NBPM_AC_DATA_ADDR)
    begin
      next_state.ac_lat = i_dm_wdata;
    end
    if (i_dm_wr && dm_b0 && i_dm_addr == `NBPM_SP_DATA_ADDR)
    begin
      next_state.sp_lat = i_dm_wdata;
    end
    if (i_dm_wr && dm_b1 && i_dm_addr == `NBPM_B1_DATA_ADDR)
    begin
      next_state.b1_lat = i_dm_wdata;
    end

    // timer reset beats a simultaneous match
    if (i_tmr_reset)
    begin
      next_state.tmr_out = `NBPM_TMR_OUT_RST;
    end
    else if (i_tmr_match)
    begin
      next_state.tmr_out = ~state.tmr_out;
    end

    // data memory read
    if (i_dm_rd)
    begin
      next_state.dm_rdata = `NBPM_NIB_RST;
      if (dm_b0 && i_dm_addr == `NBPM_AC_DATA_ADDR)
      begin
        next_state.dm_rdata = ac_view;
      end
      if (dm_b0 && i_dm_addr == `NBPM_SP_DATA_ADDR)
      begin
        next_state.dm_rdata = sp_view;
      end
      if (dm_b1 && i_dm_addr == `NBPM_B1_DATA_ADDR)
      begin
        next_state.dm_rdata = b1_view;
      end
    end

    // register file read, unmapped reads as zero
    if (i_rf_rd)
    begin
      case (i_rf_addr)
        `NBPM_ALT_SEL_ADDR:
        begin
          next_state.rf_rdata = state.alt_sel;
        end
        `NBPM_ANA_SEL_ADDR:
        begin
          next_state.rf_rdata = state.ana_sel;
        end
        `NBPM_AC_DIR_ADDR:
        begin
          next_state.rf_rdata = state.ac_dir;
        end
        `NBPM_CHAN_SEL_ADDR:
        begin
          next_state.rf_rdata = {2'h0, state.chan};
        end
        `NBPM_SP_DIR_ADDR:
        begin
          next_state.rf_rdata = state.sp_dir;
        end
        `NBPM_GRP_DIR_ADDR:
        begin
          next_state.rf_rdata = state.grp_dir;
        end
        default:
        begin
          next_state.rf_rdata = `NBPM_NIB_RST;
        end
      endcase
    end

    // pins follow the current configuration one cycle later
    next_state.ac_out = state.ac_lat;
    // an analog pin with direction 1 still drives and corrupts the sample
    next_state.ac_oe_n = ~state.ac_dir;
    next_state.route = state.ana_sel;
    next_state.conv_chan = state.chan;

    // open drain: enable only while pulling low
    next_state.sp_oe_n = ~(state.sp_dir & ~state.sp_lat);
    if (serial_pins_enable)
    begin
      next_state.sp_oe_n[`NBPM_SCK_BIT] = ~(i_sck_internal & ~i_sck_drive);
      next_state.sp_oe_n[`NBPM_SO_BIT] = i_so_drive;
      next_state.sp_oe_n[`NBPM_SI_BIT] = 1'b1;
    end
    if (timer_pin_select)
    begin
      next_state.sp_oe_n[`NBPM_TMR_BIT] = state.tmr_out;
    end

    next_state.b1_oe_n = bank1_group_dir ? state.b1_lat : `NBPM_ALL_HIGH;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= '0;
      state.ac_oe_n <= `NBPM_ALL_HIGH;
      state.sp_oe_n <= `NBPM_ALL_HIGH;
      state.b1_oe_n <= `NBPM_ALL_HIGH;
      state.chan <= `NBPM_CHAN_RST;
      state.tmr_out <= `NBPM_TMR_OUT_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // serial side sees synchronised pin levels through its own flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      serial_q <= 1'b0;
      sck_q <= 1'b0;
      si_q <= 1'b0;
    end
    else
    begin
      serial_q <= serial_pins_enable;
      sck_q <= sp_level[`NBPM_SCK_BIT];
      si_q <= sp_level[`NBPM_SI_BIT];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_dm_rdata = state.dm_rdata;
  assign o_rf_rdata = state.rf_rdata;
  assign o_ac_pin_out = state.ac_out;
  assign o_ac_pin_oe_n = state.ac_oe_n;
  assign o_analog_route = state.route;
  assign o_conv_chan = state.conv_chan;
  assign o_sp_pin_out = `NBPM_NIB_RST;
  assign o_sp_pin_oe_n = state.sp_oe_n;
  assign o_b1_pin_out = `NBPM_NIB_RST;
  assign o_b1_pin_oe_n = state.b1_oe_n;
  assign o_serial_pins_enable = serial_q;
  assign o_serial_clk_in = sck_q;
  assign o_serial_data_in = si_q;
  assign o_timer_toggle_output = state.tmr_out;

endmodule

// >>> nbpm_checker.sv
// concurrent checks on the nibble port block ports
`include "nbpm_params.svh"

module nbpm_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_dm_bank,
  input wire logic [`NBPM_DM_AW-1:0] i_dm_addr,
  input wire logic i_dm_wr,
  input wire nbpm_pkg::nbpm_nib_type i_dm_wdata,
  input wire logic [`NBPM_RF_AW-1:0] i_rf_addr,
  input wire logic i_rf_wr,
  input wire nbpm_pkg::nbpm_nib_type i_rf_wdata,
  input wire logic i_tmr_reset,
  input wire logic i_tmr_match,
  input wire nbpm_pkg::nbpm_nib_type o_ac_pin_out,
  input wire nbpm_pkg::nbpm_nib_type o_ac_pin_oe_n,
  input wire nbpm_pkg::nbpm_nib_type o_analog_route,
  input wire logic [1:0] o_conv_chan,
  input wire nbpm_pkg::nbpm_nib_type o_b1_pin_oe_n,
  input wire logic o_timer_toggle_output
);
  timeunit 1ns;
  timeprecision 1ps;
  import nbpm_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // mirror of the bank1 latch: open drain only pulls low where the latch holds 0
  nbpm_nib_type b1_lat_m;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      b1_lat_m <= 4'h0;
    end
    else if (i_dm_wr && i_dm_bank == `NBPM_BANK1 && i_dm_addr == `NBPM_B1_DATA_ADDR)
    begin
      b1_lat_m <= i_dm_wdata;
    end
  end
  // ****
  // config writes reach the pins two edges later
  // ****
  sequence s_rf(logic [5:0] a);
    i_rf_wr && i_rf_addr == a;
  endsequence
  sequence s_ac_wr;
    i_dm_wr && i_dm_bank == `NBPM_BANK0 && i_dm_addr == `NBPM_AC_DATA_ADDR;
  endsequence
  property p_rst;
    $rose(i_arst_n) |-> o_ac_pin_oe_n == 4'hf && o_b1_pin_oe_n == 4'hf && o_analog_route == 4'h0
      && o_conv_chan == 2'h0 && o_ac_pin_out == 4'h0 && o_timer_toggle_output;
  endproperty
  property p_ac_dir;
    s_rf(`NBPM_AC_DIR_ADDR) |-> ##2 o_ac_pin_oe_n == ~$past(i_rf_wdata, 2);
  endproperty
  property p_ac_lat;
    s_ac_wr |-> ##2 o_ac_pin_out == $past(i_dm_wdata, 2);
  endproperty
  property p_route;
    s_rf(`NBPM_ANA_SEL_ADDR) |-> ##2 o_analog_route == $past(i_rf_wdata, 2);
  endproperty
  property p_chan;
    s_rf(`NBPM_CHAN_SEL_ADDR) |-> ##2 o_conv_chan == $past(i_rf_wdata[1:0], 2);
  endproperty
  property p_b1_dir;
    s_rf(`NBPM_GRP_DIR_ADDR) |-> ##2 o_b1_pin_oe_n == ($past(i_rf_wdata[2], 2) ? $past(b1_lat_m) : 4'hf);
  endproperty
  property p_tmr_rst;
    i_tmr_reset |=> o_timer_toggle_output;
  endproperty
  property p_tmr_tog;
    i_tmr_match && !i_tmr_reset |=> o_timer_toggle_output != $past(o_timer_toggle_output);
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_ac_dir: assert property (p_ac_dir) else $error("analog port drive enable wrong");
  a_ac_lat: assert property (p_ac_lat) else $error("analog port drive value wrong");
  a_route: assert property (p_route) else $error("converter routing wrong");
  a_chan: assert property (p_chan) else $error("converter channel wrong");
  a_b1_dir: assert property (p_b1_dir) else $error("bank1 drive enable wrong");
  a_tmr_rst: assert property (p_tmr_rst) else $error("timer output not high after reset");
  a_tmr_tog: assert property (p_tmr_tog) else $error("timer output did not toggle");
endmodule

bind nbpm_top nbpm_checker i_nbpm_checker (.i_clk, .i_arst_n, .i_dm_bank, .i_dm_addr, .i_dm_wr, .i_dm_wdata,
  .i_rf_addr, .i_rf_wr, .i_rf_wdata, .i_tmr_reset, .i_tmr_match, .o_ac_pin_out, .o_ac_pin_oe_n,
  .o_analog_route, .o_conv_chan, .o_b1_pin_oe_n, .o_timer_toggle_output);

// >>> nbpm_pins.sv
// board model of the pins around the three ports
module nbpm_pins (
  input wire nbpm_pkg::nbpm_nib_type i_ac_out,
  input wire nbpm_pkg::nbpm_nib_type i_ac_oe_n,
  input wire nbpm_pkg::nbpm_nib_type i_ac_ext,
  input wire nbpm_pkg::nbpm_nib_type i_sp_oe_n,
  input wire nbpm_pkg::nbpm_nib_type i_sp_ext,
  input wire nbpm_pkg::nbpm_nib_type i_b1_oe_n,
  input wire nbpm_pkg::nbpm_nib_type i_b1_ext,
  output nbpm_pkg::nbpm_nib_type o_ac,
  output nbpm_pkg::nbpm_nib_type o_sp,
  output nbpm_pkg::nbpm_nib_type o_b1
);
  timeunit 1ns;
  timeprecision 1ps;
  import nbpm_pkg::*;
  // ****
  // wire levels
  // ****
  // push-pull driver overrides the source, so a driven analog pin is disturbed
  assign o_ac = (i_ac_out & ~i_ac_oe_n) | (i_ac_ext & i_ac_oe_n);
  // open drain with pull-up: either party may pull low
  assign o_sp = i_sp_ext & i_sp_oe_n;
  assign o_b1 = i_b1_ext & i_b1_oe_n;
endmodule

// >>> nbpm_top_test.sv
// self-checking bench for the nibble port block
module nbpm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nbpm_pkg::*;
  logic i_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic i_dm_bank = 1'h0, i_dm_wr = 1'h0, i_dm_rd = 1'h0, i_rf_wr = 1'h0, i_rf_rd = 1'h0;
  logic i_sck_internal = 1'h0, i_sck_drive = 1'h1, i_so_drive = 1'h1, i_so_latch_load = 1'h0;
  logic i_so_latch_val = 1'h0, i_tmr_reset = 1'h0, i_tmr_match = 1'h0;
  logic [6:0] i_dm_addr = 7'h00;
  logic [5:0] i_rf_addr = 6'h00;
  nbpm_nib_type i_dm_wdata = 4'h0, i_rf_wdata = 4'h0, ac_ext = 4'hf, sp_ext = 4'hf, b1_ext = 4'hf;
  nbpm_nib_type i_ac_pin, i_sp_pin, i_b1_pin, o_dm_rdata, o_rf_rdata, o_ac_pin_out, o_ac_pin_oe_n;
  nbpm_nib_type o_analog_route, o_sp_pin_out, o_sp_pin_oe_n, o_b1_pin_out, o_b1_pin_oe_n;
  logic [1:0] o_conv_chan;
  logic o_serial_pins_enable, o_serial_clk_in, o_serial_data_in, o_timer_toggle_output;
  int mismatches = 0;
  int tests_run = 0;
  int al, sl, bl, ad, rt, ch, sd, gd, alt, t, sp_p, sp_low;

  always #5 i_clk = ~i_clk;

  nbpm_top i_nbpm_top (.i_clk, .i_arst_n, .i_dm_bank, .i_dm_addr, .i_dm_wr, .i_dm_rd, .i_dm_wdata, .o_dm_rdata,
    .i_rf_addr, .i_rf_wr, .i_rf_rd, .i_rf_wdata, .o_rf_rdata, .i_ac_pin, .o_ac_pin_out, .o_ac_pin_oe_n,
    .o_analog_route, .o_conv_chan, .i_sp_pin, .o_sp_pin_out, .o_sp_pin_oe_n, .i_b1_pin, .o_b1_pin_out,
    .o_b1_pin_oe_n, .i_sck_internal, .i_sck_drive, .i_so_drive, .i_so_latch_load, .i_so_latch_val,
    .i_tmr_reset, .i_tmr_match, .o_serial_pins_enable, .o_serial_clk_in, .o_serial_data_in,
    .o_timer_toggle_output);

  nbpm_pins i_nbpm_pins (.i_ac_out(o_ac_pin_out), .i_ac_oe_n(o_ac_pin_oe_n), .i_ac_ext(ac_ext),
    .i_sp_oe_n(o_sp_pin_oe_n), .i_sp_ext(sp_ext), .i_b1_oe_n(o_b1_pin_oe_n), .i_b1_ext(b1_ext),
    .o_ac(i_ac_pin), .o_sp(i_sp_pin), .o_b1(i_b1_pin));

  // ****
  // bus tasks
  // ****
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  // one idle edge after each access so no strobe is set twice in a time step
  task automatic acc(input bit rf, input bit wr, input logic b, input int a, input int d, input int m);
    i_dm_bank = b;
    i_dm_addr = 7'(a);
    i_rf_addr = 6'(a);
    i_dm_wdata = 4'(d);
    i_rf_wdata = 4'(d);
    i_dm_wr = wr & !rf;
    i_dm_rd = !wr & !rf;
    i_rf_wr = wr & rf;
    i_rf_rd = !wr & rf;
    tick();
    {i_dm_wr, i_dm_rd, i_rf_wr, i_rf_rd} = 4'h0;
    if (!wr)
      check(rf ? o_rf_rdata & 4'(m) : o_dm_rdata & 4'(m), 4'(d & m));
    tick();
  endtask

  // ****
  // reference model
  // ****
  // serial pins released: clock and data-out drivers are held high
  function automatic int sp_view();
    int v;
    sp_low = sd & ~sl & 15;
    if (alt & 1)
      sp_low &= 8;
    if (alt & 8)
      sp_low = sp_low & 7 | (t ? 0 : 8);
    sp_p = sp_ext & ~sp_low;
    v = sd & sl | ~sd & sp_p;
    if (alt & 1)
      v = v & 8 | (i_sck_internal ? sl & 1 : sp_p & 1) | sp_p & 4;
    if (alt & 8)
      v = v & 7 | sl & 8;
    return v;
  endfunction

  task automatic do_reset();
    i_arst_n = 1'h0;
    repeat (2) tick();
    i_arst_n = 1'h1;
    {al, sl, bl, ad, rt, ch, sd, gd, alt} = '0;
    t = 1;
  endtask

  // pins need the synchroniser to settle before reads
  task automatic verify();
    repeat (8) tick();
    acc(0, 0, 0, 'h72, ac_ext & ~(ad | rt) | al & (ad | rt), 15);
    acc(0, 0, 0, 'h73, sp_view(), (alt & 1) ? 13 : 15);
    acc(0, 0, 1, 'h70, (gd & 4) ? bl : b1_ext, 15);
    acc(0, 0, 1, 'h72, 0, 15);
    acc(1, 0, 0, 'h1b, rt, 15);
    acc(1, 0, 0, 'h1c, ad, 15);
    acc(1, 0, 0, 'h22, ch, 15);
    acc(1, 0, 0, 'h2b, sd, 15);
    acc(1, 0, 0, 'h2c, gd, 15);
    acc(1, 0, 0, 'h0b, alt, 15);
    check(o_sp_pin_oe_n, 4'(~sp_low));
    check(4'(o_timer_toggle_output), 4'(t));
    check(4'(o_serial_pins_enable), 4'(alt & 1));
    check(4'(o_serial_data_in), 4'(sp_p >> 2 & 1));
    check(4'(o_serial_clk_in), 4'(sp_p & 1));
    check(o_sp_pin_out | o_b1_pin_out, 4'h0);
  endtask

  task automatic step();
    rt = $urandom % 16;
    ad = $urandom % 16 & ~rt;
    ch = $urandom % 16;
    sd = $urandom % 16;
    gd = $urandom % 16;
    alt = $urandom % 16;
    acc(1, 1, 0, 'h1b, rt, 0);
    acc(1, 1, 0, 'h1c, ad, 0);
    acc(1, 1, 0, 'h22, ch, 0);
    ch &= 3;
    acc(1, 1, 0, 'h2b, sd, 0);
    acc(1, 1, 0, 'h2c, gd, 0);
    acc(1, 1, 0, 'h0b, alt, 0);
    acc(0, 1, 1, 'h73, 15, 0);
    if ($urandom % 2)
    begin
      al = $urandom % 16;
      sl = $urandom % 16;
      bl = $urandom % 16;
      acc(0, 1, 0, 'h72, al, 0);
      acc(0, 1, 0, 'h73, sl, 0);
      acc(0, 1, 1, 'h70, bl, 0);
    end
    i_so_latch_val = 1'($urandom);
    i_so_latch_load = 1'(alt);
    i_tmr_reset = 1'($urandom);
    i_tmr_match = 1'($urandom);
    tick();
    // strobes are read before they are dropped
    t = i_tmr_reset ? 1 : t ^ i_tmr_match;
    {i_so_latch_load, i_tmr_reset, i_tmr_match} = 3'h0;
    if (alt & 1)
      sl = sl & 13 | i_so_latch_val << 1;
    i_sck_internal = 1'($urandom);
    ac_ext = 4'($urandom);
    sp_ext = 4'($urandom);
    b1_ext = 4'($urandom);
    verify();
  endtask

  task automatic results();
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // sequence and watchdog
  // ****
  initial
  begin
    void'($urandom(38193));
    do_reset();
    verify();
    repeat (40) step();
    do_reset();
    verify();
    results();
  end

  initial
  begin
    #100000;
    mismatches++;
    results();
  end
endmodule
